// ==== logic/asp_pkg.sv ====
// Shared constants, register map and state enumerations of the serial port.
package asp_pkg;

	// ----------------------------------------------------------------
	// Register map (index on the three-bit register port)
	// ----------------------------------------------------------------
	localparam logic [2:0] A_CTRL = 3'h0;
	localparam logic [2:0] A_BAUD = 3'h1;
	localparam logic [2:0] A_FRAC = 3'h2;
	localparam logic [2:0] A_TXD = 3'h3;
	localparam logic [2:0] A_RXD = 3'h4;
	localparam logic [2:0] A_STAT = 3'h5;
	localparam logic [2:0] A_MASK = 3'h6;
	localparam logic [2:0] A_IRPW = 3'h7;

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int C_SYNC = 0;
	localparam int C_NINE = 1;
	localparam int C_PAR = 2;
	localparam int C_ODD = 3;
	localparam int C_STOP2 = 4;
	localparam int C_MP = 5;
	localparam int C_WAIT = 6;
	localparam int C_IRDA = 7;
	localparam int C_IRPW = 8;
	localparam int C_LB = 9;
	localparam int C_REN = 10;
	localparam int C_RUN = 11;
	localparam int C_ABD = 12;
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [15:0] ABD_CLR = 16'h10FF;
	localparam logic [15:0] ABD_SET = 16'h0C00;

	// ----------------------------------------------------------------
	// Status and mask fields
	// ----------------------------------------------------------------
	localparam int S_TBE = 0;
	localparam int S_TDONE = 1;
	localparam int S_RBF = 2;
	localparam int S_FE = 3;
	localparam int S_PE = 4;
	localparam int S_OE = 5;
	localparam int S_ABST = 6;
	localparam int S_ABEND = 7;
	localparam logic [7:0] STAT_RST = 8'h01;

	// ----------------------------------------------------------------
	// Timing in baud ticks, frame and character lengths in bits, FIFO depth in entries
	// ----------------------------------------------------------------
	localparam logic [3:0] OVS_LAST = 4'hf;
	localparam logic [3:0] OVS_SAMPLE = 4'h7;
	localparam logic [3:0] SYNC_LAST = 4'h7;
	localparam logic [3:0] SYNC_EDGE = 4'h4;
	localparam logic [3:0] IRDA_FIX = 4'h3;
	localparam logic [3:0] SYNC_BITS = 4'h8;
	localparam logic [3:0] FRAME_BASE = 4'ha;
	localparam logic [3:0] FIFO_FULL = 4'h8;

	typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} asp_tx_type;
	typedef enum logic [0:0] {RX_IDLE, RX_BITS} asp_rx_type;
	typedef enum logic [1:0] {AB_IDLE, AB_ARM, AB_MEAS} asp_abd_type;

endpackage : asp_pkg

// ==== logic/asp_serial_port.sv ====
// Asynchronous and synchronous serial port with FIFOs, autobaud and interrupts.
`timescale 1ns/1ns

// Operation
// - Asynchronous mode is full duplex, synchronous mode half duplex.
// - Frame: start bit, 8 or 9 bits LSB first, optional parity, one or two stops.
// - Multiprocessor mode sends 8 data bits plus a wake-up bit.
// - IrDA pulse coding both ways, fixed or software-set pulse width.
// - Synchronous mode: device makes the shift clock, exactly 8 bits per character.
// - Synchronous mode always shifts the least significant bit first.
// - Baud ticks come from a generator with a fractional divider.
// - Asynchronous rates 2.5 Mbit/s down to about 0.00058 bit/s at 40 MHz.
// - Synchronous rates 5 Mbit/s down to about 0.00116 bit/s at 40 MHz.
// - Transmit and receive each buffered by an 8-entry FIFO.
// - Autobaud measures an incoming frame and loads baud and mode settings.
// - Parity generated on transmit, checked on receive, error flagged.
// - Missing stop bit raises a framing error.
// - Completing a character into a full receive buffer raises overrun.
// - Five separate interrupt request outputs.
// - Interrupts on buffer empty, last bit, receive, errors, autobaud start and end.
// - Loop-back feeds transmit data to the receiver in asynchronous mode, line untouched.
module asp_serial_port (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [2:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [15:0] rdata,
	input wire logic rxd_in,
	output logic rxd_out,
	output logic rxd_oe,
	output logic txd_out,
	output logic sclk_out,
	output logic irq_tx_buf,
	output logic irq_tx_done,
	output logic irq_rx,
	output logic irq_err,
	output logic irq_abd,
	output logic irq
);

	typedef struct packed {
		logic [15:0] ctrl;
		logic [15:0] brl;
		logic [15:0] frac;
		logic [7:0] irpw;
		logic [7:0] mask;
		logic [7:0] stat;
		logic [15:0] acc;
		logic [15:0] bcnt;
		logic tick;
		logic [7:0][8:0] txf;
		logic [2:0] txw;
		logic [2:0] txr;
		logic [3:0] txn;
		logic [7:0][8:0] rxf;
		logic [2:0] rxw;
		logic [2:0] rxr;
		logic [3:0] rxn;
		logic [15:0] rdata;
		logic [2:0] sync;
		logic rxl;
		asp_pkg::asp_tx_type tst;
		logic [11:0] tsh;
		logic [3:0] tlen;
		logic [3:0] tcnt;
		logic [3:0] tph;
		logic [7:0] tpw;
		logic trecv;
		logic tline;
		asp_pkg::asp_rx_type rst;
		logic [10:0] rsh;
		logic [3:0] rcnt;
		logic [3:0] rph;
		logic lowseen;
		asp_pkg::asp_abd_type ast;
		logic [19:0] abc;
		logic txd;
		logic sclk;
		logic rxo;
		logic rxoe;
		logic [4:0] irqv;
		logic irq;
	} asp_state_type;

	asp_state_type r_ff;
	asp_state_type nxt_r;
	logic [7:0] ev;
	logic tx_push;
	logic tx_pop;
	logic rx_push;
	logic rx_pop;
	logic [8:0] rx_word;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// A ninth frame bit exists for 9-bit data, wake-up bit or parity.
	function automatic logic asp_has_ext(input logic [15:0] c);
		asp_has_ext = c[asp_pkg::C_NINE] | c[asp_pkg::C_MP] | c[asp_pkg::C_PAR];
	endfunction : asp_has_ext

	// Frame length up to and including the first stop bit.
	function automatic logic [3:0] asp_frame_len(input logic [15:0] c);
		asp_frame_len = asp_pkg::FRAME_BASE + {3'h0, asp_has_ext(c)};
	endfunction : asp_frame_len

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------

	// All behaviour lives here; the flip-flop process only registers it.
	always_comb begin
		logic [16:0] sum;
		logic pre;
		logic line;
		logic v;
		logic [10:0] w;
		logic [8:0] d;
		logic [3:0] len;
		logic [20:0] rnd;
		nxt_r = r_ff;
		nxt_r.tick = 1'h0;
		nxt_r.rdata = 16'h0000;
		ev = 8'h00;
		tx_push = 1'h0;
		tx_pop = 1'h0;
		rx_push = 1'h0;
		rx_pop = 1'h0;
		rx_word = 9'h000;
		sum = {1'h0, r_ff.acc} + {1'h0, r_ff.frac};
		pre = 1'h0;
		v = 1'h0;
		w = 11'h000;
		d = r_ff.txf[r_ff.txr];
		len = asp_frame_len(r_ff.ctrl);
		line = 1'h1;
		rnd = {1'h0, r_ff.abc} + {17'h0_0000, asp_pkg::OVS_SAMPLE};

		// Fractional prescaler feeds the integer reload counter; a zero
		// fraction bypasses it so the fastest rate is one tick per clock.
		if (r_ff.ctrl[asp_pkg::C_RUN]) begin
			pre = (r_ff.frac == 16'h0000) ? 1'h1 : sum[16];
			nxt_r.acc = sum[15:0];
			if (pre) begin
				if (r_ff.bcnt == 16'h0000) begin
					nxt_r.bcnt = r_ff.brl;
					nxt_r.tick = 1'h1;
				end else begin
					nxt_r.bcnt = r_ff.bcnt - 16'h0001;
				end
			end
		end else begin
			nxt_r.acc = 16'h0000;
			nxt_r.bcnt = 16'h0000;
		end

		// Three-stage pin synchroniser; a level counts once stages two and three agree.
		nxt_r.sync = {r_ff.sync[1:0], rxd_in};
		if (r_ff.sync[1] == r_ff.sync[2]) begin
			nxt_r.rxl = r_ff.sync[2];
		end
		line = r_ff.ctrl[asp_pkg::C_LB] ? r_ff.tline : r_ff.rxl;

		// Transmitter, and in synchronous mode the whole half-duplex shifter.
		nxt_r.tpw = (r_ff.tpw == 8'hff) ? r_ff.tpw : r_ff.tpw + 8'h01;
		case (r_ff.tst)
			asp_pkg::TX_IDLE: begin
				nxt_r.tcnt = 4'h0;
				nxt_r.tph = 4'h0;
				nxt_r.tpw = 8'h00;
				if (r_ff.ctrl[asp_pkg::C_SYNC]) begin
					// Only one direction runs at a time, transmit first.
					if (r_ff.txn != 4'h0) begin
						tx_pop = 1'h1;
						nxt_r.tsh = {4'h0, d[7:0]};
						nxt_r.trecv = 1'h0;
						nxt_r.tlen = asp_pkg::SYNC_BITS;
						nxt_r.tst = asp_pkg::TX_SHIFT;
					end else if (r_ff.ctrl[asp_pkg::C_REN]) begin
						nxt_r.tsh = 12'h000;
						nxt_r.trecv = 1'h1;
						nxt_r.tlen = asp_pkg::SYNC_BITS;
						nxt_r.tst = asp_pkg::TX_SHIFT;
					end
				end else if (r_ff.txn != 4'h0) begin
					// Start, data LSB first, optional ninth bit, stop bits.
					tx_pop = 1'h1;
					nxt_r.trecv = 1'h0;
					nxt_r.tsh = {2'h3, !asp_has_ext(r_ff.ctrl) ? 1'h1 :
						r_ff.ctrl[asp_pkg::C_PAR] ? ^d[7:0] ^ r_ff.ctrl[asp_pkg::C_ODD] :
						d[8], d[7:0], 1'h0};
					nxt_r.tlen = len + {3'h0, r_ff.ctrl[asp_pkg::C_STOP2]};
					nxt_r.tst = asp_pkg::TX_SHIFT;
				end
			end
			asp_pkg::TX_SHIFT: begin
				if (r_ff.tick) begin
					nxt_r.tph = r_ff.tph + 4'h1;
					// Received synchronous bits enter at bit 7 so the byte ends LSB first.
					if (r_ff.ctrl[asp_pkg::C_SYNC] && r_ff.trecv && r_ff.tph == asp_pkg::SYNC_EDGE) begin
						nxt_r.tsh = {4'h0, r_ff.rxl, r_ff.tsh[7:1]};
					end
					if (r_ff.tph == (r_ff.ctrl[asp_pkg::C_SYNC] ? asp_pkg::SYNC_LAST : asp_pkg::OVS_LAST)) begin
						nxt_r.tph = 4'h0;
						nxt_r.tpw = 8'h00;
						nxt_r.tcnt = r_ff.tcnt + 4'h1;
						if (!r_ff.trecv) begin
							nxt_r.tsh = {1'h1, r_ff.tsh[11:1]};
						end
						if (r_ff.tcnt == r_ff.tlen - 4'h1) begin
							nxt_r.tst = asp_pkg::TX_IDLE;
							if (r_ff.trecv) begin
								rx_push = 1'h1;
								rx_word = {1'h0, r_ff.tsh[7:0]};
								nxt_r.ctrl[asp_pkg::C_REN] = 1'h0;
							end else begin
								ev[asp_pkg::S_TDONE] = 1'h1;
							end
						end
					end
				end
			end
			default: nxt_r.tst = asp_pkg::TX_IDLE;
		endcase

		// Asynchronous receiver, sampling at mid-bit on the 16x ticks.
		case (r_ff.rst)
			asp_pkg::RX_IDLE: begin
				nxt_r.rph = 4'h0;
				nxt_r.rcnt = 4'h0;
				if (!r_ff.ctrl[asp_pkg::C_SYNC] && r_ff.ctrl[asp_pkg::C_REN] &&
						!r_ff.ctrl[asp_pkg::C_ABD] && !line) begin
					nxt_r.lowseen = 1'h1;
					nxt_r.rst = asp_pkg::RX_BITS;
				end
			end
			asp_pkg::RX_BITS: begin
				if (!line) begin
					nxt_r.lowseen = 1'h1;
				end
				if (r_ff.tick) begin
					nxt_r.rph = r_ff.rph + 4'h1;
					if (r_ff.rph == asp_pkg::OVS_LAST) begin
						nxt_r.lowseen = 1'h0;
					end
					if (r_ff.rph == asp_pkg::OVS_SAMPLE) begin
						// An IrDA zero is any low pulse seen since the bit began.
						v = r_ff.ctrl[asp_pkg::C_IRDA] ? !(r_ff.lowseen | !line) : line;
						nxt_r.rcnt = r_ff.rcnt + 4'h1;
						nxt_r.rsh = {v, r_ff.rsh[10:1]};
						w = nxt_r.rsh >> (4'hb - len);
						if (r_ff.rcnt == 4'h0 && v) begin
							nxt_r.rst = asp_pkg::RX_IDLE;
						end else if (r_ff.rcnt == len - 4'h1) begin
							nxt_r.rst = asp_pkg::RX_IDLE;
							if (!(r_ff.ctrl[asp_pkg::C_MP] && r_ff.ctrl[asp_pkg::C_WAIT] && !w[9])) begin
								rx_push = 1'h1;
								rx_word = {asp_has_ext(r_ff.ctrl) & !r_ff.ctrl[asp_pkg::C_PAR] & w[9], w[8:1]};
								ev[asp_pkg::S_FE] = !v;
								ev[asp_pkg::S_PE] = r_ff.ctrl[asp_pkg::C_PAR] &&
									((^w[8:1] ^ r_ff.ctrl[asp_pkg::C_ODD]) != w[9]);
							end
						end
					end
				end
			end
			default: nxt_r.rst = asp_pkg::RX_IDLE;
		endcase

		// Autobaud: the start bit of an incoming character with a set LSB is
		// timed in clocks; the count over sixteen ticks per bit, rounded to the nearest clock,
		// gives the reload value, so a count one clock short still lands right.
		case (r_ff.ast)
			asp_pkg::AB_IDLE: begin
				if (r_ff.ctrl[asp_pkg::C_ABD] && !r_ff.ctrl[asp_pkg::C_SYNC]) begin
					nxt_r.ast = asp_pkg::AB_ARM;
				end
			end
			asp_pkg::AB_ARM: begin
				nxt_r.abc = 20'h0_0000;
				if (!r_ff.ctrl[asp_pkg::C_ABD]) begin
					nxt_r.ast = asp_pkg::AB_IDLE;
				end else if (!r_ff.rxl) begin
					ev[asp_pkg::S_ABST] = 1'h1;
					nxt_r.ast = asp_pkg::AB_MEAS;
				end
			end
			asp_pkg::AB_MEAS: begin
				nxt_r.abc = (r_ff.abc == 20'hF_FFFF) ? r_ff.abc : r_ff.abc + 20'h0_0001;
				if (!r_ff.ctrl[asp_pkg::C_ABD]) begin
					nxt_r.ast = asp_pkg::AB_IDLE;
				end else if (r_ff.rxl) begin
					nxt_r.brl = rnd[20] ? 16'hffff : (rnd[19:4] == 16'h0000) ? 16'h0000 : rnd[19:4] - 16'h0001;
					nxt_r.frac = 16'h0000;
					nxt_r.ctrl = (r_ff.ctrl & ~asp_pkg::ABD_CLR) | asp_pkg::ABD_SET;
					ev[asp_pkg::S_ABEND] = 1'h1;
					nxt_r.ast = asp_pkg::AB_IDLE;
				end
			end
			default: nxt_r.ast = asp_pkg::AB_IDLE;
		endcase

		// Register port; writes to control, baud and fraction win over hardware updates of those fields.
		if (wr_stb) begin
			case (addr)
				asp_pkg::A_CTRL: nxt_r.ctrl = wdata;
				asp_pkg::A_BAUD: nxt_r.brl = wdata;
				asp_pkg::A_FRAC: nxt_r.frac = wdata;
				asp_pkg::A_TXD: tx_push = (r_ff.txn != asp_pkg::FIFO_FULL);
				asp_pkg::A_MASK: nxt_r.mask = wdata[7:0];
				asp_pkg::A_IRPW: nxt_r.irpw = wdata[7:0];
				default: nxt_r.ctrl = nxt_r.ctrl;
			endcase
		end
		if (rd_stb) begin
			case (addr)
				asp_pkg::A_CTRL: nxt_r.rdata = r_ff.ctrl;
				asp_pkg::A_BAUD: nxt_r.rdata = r_ff.brl;
				asp_pkg::A_FRAC: nxt_r.rdata = r_ff.frac;
				asp_pkg::A_RXD: begin
					rx_pop = (r_ff.rxn != 4'h0);
					nxt_r.rdata = rx_pop ? {7'h00, r_ff.rxf[r_ff.rxr]} : 16'h0000;
				end
				asp_pkg::A_STAT: nxt_r.rdata = {4'h0, r_ff.rxn, r_ff.stat};
				asp_pkg::A_MASK: nxt_r.rdata = {8'h00, r_ff.mask};
				asp_pkg::A_IRPW: nxt_r.rdata = {8'h00, r_ff.irpw};
				default: nxt_r.rdata = 16'h0000;
			endcase
		end

		// FIFOs; a character finished into a full receive FIFO is dropped.
		if (tx_push) begin
			nxt_r.txf[r_ff.txw] = wdata[8:0];
			nxt_r.txw = r_ff.txw + 3'h1;
		end
		if (tx_pop) begin
			nxt_r.txr = r_ff.txr + 3'h1;
			ev[asp_pkg::S_TBE] = (r_ff.txn == 4'h1) && !tx_push;
		end
		nxt_r.txn = r_ff.txn + {3'h0, tx_push} - {3'h0, tx_pop};
		if (rx_push) begin
			ev[asp_pkg::S_RBF] = 1'h1;
			ev[asp_pkg::S_OE] = (r_ff.rxn == asp_pkg::FIFO_FULL) && !rx_pop;
		end
		if (rx_push && !ev[asp_pkg::S_OE]) begin
			nxt_r.rxf[r_ff.rxw] = rx_word;
			nxt_r.rxw = r_ff.rxw + 3'h1;
		end
		if (rx_pop) begin
			nxt_r.rxr = r_ff.rxr + 3'h1;
		end
		nxt_r.rxn = r_ff.rxn + {3'h0, rx_push && !ev[asp_pkg::S_OE]} - {3'h0, rx_pop};

		// Sticky status: write one to clear, and an event in the same cycle wins.
		nxt_r.stat = ((wr_stb && addr == asp_pkg::A_STAT) ? r_ff.stat & ~wdata[7:0] : r_ff.stat) | ev;

		// Line drivers, all taken from next state so the outputs are flops.
		// IrDA zero is a low pulse of 3/16 bit or of a programmed clock count.
		nxt_r.tline = 1'h1;
		if (nxt_r.tst == asp_pkg::TX_SHIFT && !nxt_r.ctrl[asp_pkg::C_SYNC]) begin
			nxt_r.tline = !nxt_r.ctrl[asp_pkg::C_IRDA] ? nxt_r.tsh[0] :
				nxt_r.tsh[0] | (nxt_r.ctrl[asp_pkg::C_IRPW] ? nxt_r.tpw >= nxt_r.irpw : nxt_r.tph >= asp_pkg::IRDA_FIX);
		end
		nxt_r.txd = nxt_r.ctrl[asp_pkg::C_LB] | nxt_r.tline;
		nxt_r.sclk = nxt_r.ctrl[asp_pkg::C_SYNC] && nxt_r.tst == asp_pkg::TX_SHIFT &&
			nxt_r.tph >= asp_pkg::SYNC_EDGE;
		nxt_r.rxo = nxt_r.tsh[0];
		nxt_r.rxoe = nxt_r.ctrl[asp_pkg::C_SYNC] && nxt_r.tst == asp_pkg::TX_SHIFT && !nxt_r.trecv;

		// Five request lines plus one summary level.
		nxt_r.irqv[0] = nxt_r.stat[asp_pkg::S_TBE] & nxt_r.mask[asp_pkg::S_TBE];
		nxt_r.irqv[1] = nxt_r.stat[asp_pkg::S_TDONE] & nxt_r.mask[asp_pkg::S_TDONE];
		nxt_r.irqv[2] = nxt_r.stat[asp_pkg::S_RBF] & nxt_r.mask[asp_pkg::S_RBF];
		nxt_r.irqv[3] = |(nxt_r.stat[asp_pkg::S_OE:asp_pkg::S_FE] & nxt_r.mask[asp_pkg::S_OE:asp_pkg::S_FE]);
		nxt_r.irqv[4] = |(nxt_r.stat[asp_pkg::S_ABEND:asp_pkg::S_ABST] & nxt_r.mask[asp_pkg::S_ABEND:asp_pkg::S_ABST]);
		nxt_r.irq = |nxt_r.irqv;
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------

	// Reset loads constants only; status starts with the empty-buffer flag.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			r_ff <= '0;
			r_ff.ctrl <= asp_pkg::CTRL_RST;
			r_ff.stat <= asp_pkg::STAT_RST;
			r_ff.rxl <= 1'h1;
			r_ff.sync <= 3'h7;
			r_ff.tline <= 1'h1;
			r_ff.txd <= 1'h1;
			r_ff.tst <= asp_pkg::TX_IDLE;
			r_ff.rst <= asp_pkg::RX_IDLE;
			r_ff.ast <= asp_pkg::AB_IDLE;
		end else begin
			r_ff <= nxt_r;
		end
	end

	assign rdata = r_ff.rdata;
	assign rxd_out = r_ff.rxo;
	assign rxd_oe = r_ff.rxoe;
	assign txd_out = r_ff.txd;
	assign sclk_out = r_ff.sclk;
	assign irq_tx_buf = r_ff.irqv[0];
	assign irq_tx_done = r_ff.irqv[1];
	assign irq_rx = r_ff.irqv[2];
	assign irq_err = r_ff.irqv[3];
	assign irq_abd = r_ff.irqv[4];
	assign irq = r_ff.irq;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_sync_last;
		r_ff.tst == asp_pkg::TX_SHIFT && r_ff.ctrl[asp_pkg::C_SYNC] && r_ff.tick &&
			r_ff.tph == asp_pkg::SYNC_LAST && r_ff.tcnt == 4'h7;
	endsequence
	property p_sync_eight;
		s_sync_last |=> r_ff.tst == asp_pkg::TX_IDLE ##1 !r_ff.sclk;
	endproperty
	a_sync_eight: assert property (p_sync_eight) else $error("sync transfer not ended after 8 bits");
	property p_fifo_bound;
		r_ff.txn <= asp_pkg::FIFO_FULL && r_ff.rxn <= asp_pkg::FIFO_FULL;
	endproperty
	a_fifo_bound: assert property (p_fifo_bound) else $error("fifo count above eight");
	property p_overrun;
		rx_push && r_ff.rxn == asp_pkg::FIFO_FULL && !rx_pop |=> r_ff.stat[asp_pkg::S_OE] && r_ff.rxn == asp_pkg::FIFO_FULL;
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not flagged");
	property p_tbe;
		tx_pop && r_ff.txn == 4'h1 && !tx_push |=> r_ff.stat[asp_pkg::S_TBE] && r_ff.txn == 4'h0;
	endproperty
	a_tbe: assert property (p_tbe) else $error("buffer empty not flagged");
	property p_irq;
		r_ff.irq == |(r_ff.stat & r_ff.mask);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt level differs from masked status");
	property p_loop;
		r_ff.ctrl[asp_pkg::C_LB] |-> r_ff.txd;
	endproperty
	a_loop: assert property (p_loop) else $error("line driven during loop-back");
	property p_brg_max;
		r_ff.ctrl[asp_pkg::C_RUN] && r_ff.brl == 16'h0000 && r_ff.frac == 16'h0000 && r_ff.bcnt == 16'h0000 &&
			!wr_stb |=> r_ff.tick;
	endproperty
	a_brg_max: assert property (p_brg_max) else $error("fastest divider missed a tick");
	property p_abd_end;
		r_ff.ast == asp_pkg::AB_MEAS && r_ff.rxl && r_ff.ctrl[asp_pkg::C_ABD] && !wr_stb |=>
			!r_ff.ctrl[asp_pkg::C_ABD] && r_ff.stat[asp_pkg::S_ABEND] && r_ff.ctrl[asp_pkg::C_RUN];
	endproperty
	a_abd_end: assert property (p_abd_end) else $error("autobaud end not applied");
	property p_par_tx;
		r_ff.tst == asp_pkg::TX_IDLE && nxt_r.tst == asp_pkg::TX_SHIFT && !r_ff.ctrl[asp_pkg::C_SYNC] &&
			r_ff.ctrl[asp_pkg::C_PAR] |=> r_ff.tsh[9] == (^r_ff.tsh[8:1] ^ r_ff.ctrl[asp_pkg::C_ODD]);
	endproperty
	a_par_tx: assert property (p_par_tx) else $error("parity bit wrong");

endmodule : asp_serial_port

// ==== verif/asp_line_model.sv ====
// Line-side partner: a terminal that sends frames to the port and captures its frames.
`timescale 1ns/1ns
module asp_line_model #(
	parameter int BIT_CLKS = 16
) (
	input wire logic clk,
	input wire logic line_in,
	output logic line_out
);
	// ------------
	// Frame driver
	// ------------
	// The line idles high between frames, as an asynchronous line must.
	initial begin
		line_out = 1'b1;
	end

	// Sends the bits LSB first, each held for one whole bit time.
	task automatic send(input logic [11:0] bits, input int n);
		for (int i = 0; i < n; i++) begin
			line_out <= bits[i];
			repeat (BIT_CLKS) @(posedge clk);
		end
		line_out <= 1'b1;
	endtask : send

	// Waits a bounded time for a start bit, then samples each bit at its middle.
	task automatic recv(output logic [11:0] bits, input int n);
		int w;
		bits = '0;
		w = 0;
		while (line_in !== 1'b0 && w < 400) begin
			@(posedge clk);
			w++;
		end
		repeat (BIT_CLKS / 2) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			bits[i] = line_in;
			repeat (BIT_CLKS) @(posedge clk);
		end
	endtask : recv
endmodule : asp_line_model

// ==== verif/asp_serial_port_tb.sv ====
// Self-checking bench for the serial port over its register port and its line.
`timescale 1ns/1ns
module asp_serial_port_tb;
	// ---------------------
	// Signals and instances
	// ---------------------
	logic clk, nrst, wr_stb, rd_stb, rxd_out, rxd_oe, txd_out, sclk_out, line_drv, prev;
	logic irq_tx_buf, irq_tx_done, irq_rx, irq_err, irq_abd, irq;
	logic [2:0] addr;
	logic [15:0] wdata, rdata, val;
	logic [11:0] frame;
	logic [7:0] got;
	int miscompares = 0;
	int cmp_count = 0;
	int cycles = 0;
	int edges;
	// The shared pin shows the device while it drives, else the line partner.
	wire rxd_wire = rxd_oe ? rxd_out : line_drv;

	asp_serial_port dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
		.rd_stb(rd_stb), .rdata(rdata), .rxd_in(rxd_wire), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
		.txd_out(txd_out), .sclk_out(sclk_out), .irq_tx_buf(irq_tx_buf), .irq_tx_done(irq_tx_done),
		.irq_rx(irq_rx), .irq_err(irq_err), .irq_abd(irq_abd), .irq(irq));
	asp_line_model #(.BIT_CLKS(16)) peer (.clk(clk), .line_in(txd_out), .line_out(line_drv));

	// Clock of 50 ns period.
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// ---------------
	// Access helpers
	// ---------------
	task automatic cmp(input logic [15:0] g, input logic [15:0] e);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask : cmp

	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe, so they are taken there.
	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
		#1 d = rdata;
	endtask : rd

	task automatic chk(input logic [2:0] a, input logic [15:0] m, input logic [15:0] e);
		rd(a, val);
		cmp(val & m, e);
	endtask : chk

	// Empties the receive FIFO and clears every status flag.
	task automatic drain();
		repeat (8) rd(asp_pkg::A_RXD, val);
		wr(asp_pkg::A_STAT, 16'h00ff);
	endtask : drain

	task automatic rx_frame(input logic [11:0] b, input int n);
		peer.send(b, n);
		repeat (4) @(posedge clk);
	endtask : rx_frame

	// Counts the clocks in which the transmit pin is not high.
	task automatic watch_txd(input int n);
		edges = 0;
		repeat (n) begin
			@(posedge clk);
			if (txd_out !== 1'b1) edges++;
		end
	endtask : watch_txd

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : conclude

	// A hang is cut short well beyond the expected run of a few thousand cycles.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			miscompares++;
			conclude();
		end
	end

	// ---------
	// Scenarios
	// ---------
	initial begin
		nrst = 1'b0;
		addr = '0;
		wdata = '0;
		wr_stb = 1'b0;
		rd_stb = 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		// Reset values, then an 8N1 transmit and its status flags.
		chk(asp_pkg::A_STAT, 16'hffff, 16'h0001);
		chk(asp_pkg::A_CTRL, 16'hffff, 16'h0000);
		wr(asp_pkg::A_CTRL, 16'h0c00);
		wr(asp_pkg::A_TXD, 16'h00a5);
		peer.recv(frame, 10);
		cmp({4'h0, frame}, 16'h034a);
		repeat (4) @(posedge clk);
		chk(asp_pkg::A_STAT, 16'h0003, 16'h0003);
		chk(asp_pkg::A_TXD, 16'hffff, 16'h0000);
		wr(asp_pkg::A_MASK, 16'h0003);
		repeat (2) @(posedge clk);
		cmp({14'h0, irq_tx_buf, irq_tx_done}, 16'h0003);
		// Receive, then the interrupt masked, unmasked and cleared.
		wr(asp_pkg::A_STAT, 16'h00ff);
		rx_frame(12'h278, 10);
		chk(asp_pkg::A_STAT, 16'h0f04, 16'h0104);
		cmp({15'h0, irq_rx}, 16'h0000);
		wr(asp_pkg::A_MASK, 16'h0004);
		repeat (2) @(posedge clk);
		cmp({14'h0, irq_rx, irq}, 16'h0003);
		wr(asp_pkg::A_STAT, 16'h0004);
		repeat (2) @(posedge clk);
		cmp({14'h0, irq_rx, irq}, 16'h0000);
		chk(asp_pkg::A_RXD, 16'hffff, 16'h003c);
		chk(asp_pkg::A_RXD, 16'hffff, 16'h0000);
		wr(asp_pkg::A_MASK, 16'h0000);
		// Even parity appended on transmit, a wrong one flagged on receive.
		wr(asp_pkg::A_CTRL, 16'h0c04);
		wr(asp_pkg::A_TXD, 16'h0007);
		peer.recv(frame, 11);
		cmp({4'h0, frame}, 16'h060e);
		rx_frame(12'h402, 11);
		chk(asp_pkg::A_STAT, 16'h0010, 16'h0010);
		drain();
		// A missing stop bit.
		wr(asp_pkg::A_CTRL, 16'h0c00);
		rx_frame(12'h0aa, 10);
		chk(asp_pkg::A_STAT, 16'h0008, 16'h0008);
		wr(asp_pkg::A_MASK, 16'h0038);
		repeat (2) @(posedge clk);
		cmp({15'h0, irq_err}, 16'h0001);
		drain();
		// Nine characters into an eight-entry FIFO.
		for (int i = 0; i < 9; i++) begin
			rx_frame({3'b001, 4'h1, 4'(i), 1'b0}, 10);
		end
		chk(asp_pkg::A_STAT, 16'h0f20, 16'h0820);
		chk(asp_pkg::A_RXD, 16'hffff, 16'h0010);
		drain();
		// Waiting for an address: a data frame is dropped, an address frame kept.
		wr(asp_pkg::A_CTRL, 16'h0c60);
		rx_frame(12'h422, 11);
		chk(asp_pkg::A_STAT, 16'h0f04, 16'h0000);
		rx_frame(12'h644, 11);
		chk(asp_pkg::A_RXD, 16'hffff, 16'h0122);
		drain();
		// Loop-back: the character returns while the line stays idle.
		wr(asp_pkg::A_CTRL, 16'h0e00);
		wr(asp_pkg::A_TXD, 16'h005a);
		watch_txd(180);
		cmp(16'(edges), 16'h0000);
		chk(asp_pkg::A_RXD, 16'hffff, 16'h005a);
		// IrDA: two zero bits give 3 short low clocks each, then 5 programmed ones; loop-back decodes.
		wr(asp_pkg::A_CTRL, 16'h0c80);
		wr(asp_pkg::A_TXD, 16'h00fe);
		watch_txd(180);
		cmp(16'(edges), 16'h0006);
		wr(asp_pkg::A_IRPW, 16'h0005);
		wr(asp_pkg::A_CTRL, 16'h0d80);
		wr(asp_pkg::A_TXD, 16'h00fe);
		watch_txd(180);
		cmp(16'(edges), 16'h000a);
		wr(asp_pkg::A_CTRL, 16'h0e80);
		wr(asp_pkg::A_TXD, 16'h00c3);
		watch_txd(180);
		chk(asp_pkg::A_RXD, 16'hffff, 16'h00c3);
		// Synchronous transmit: eight clock pulses, LSB first, pin driven meanwhile.
		wr(asp_pkg::A_CTRL, 16'h0801);
		wr(asp_pkg::A_TXD, 16'h0096);
		edges = 0;
		prev = 1'b0;
		got = '0;
		repeat (150) begin
			@(posedge clk);
			if (sclk_out === 1'b1 && prev === 1'b0) begin
				if (edges < 8) got[edges] = rxd_out & rxd_oe;
				edges++;
			end
			prev = sclk_out;
		end
		cmp(16'(edges), 16'h0008);
		cmp({8'h0, got}, 16'h0096);
		cmp({14'h0, sclk_out, rxd_oe}, 16'h0000);
		// Synchronous receive from an idle high pin: eight ones, enable dropped at the end.
		wr(asp_pkg::A_CTRL, 16'h0c01);
		repeat (80) @(posedge clk);
		chk(asp_pkg::A_CTRL, 16'h0400, 16'h0000);
		chk(asp_pkg::A_RXD, 16'hffff, 16'h00ff);
		// Autobaud over a start bit two bit times long: reload 1, 8N1 with run and receive.
		wr(asp_pkg::A_CTRL, 16'h1040);
		wr(asp_pkg::A_MASK, 16'h00c0);
		wr(asp_pkg::A_STAT, 16'h00ff);
		rx_frame(12'hffc, 12);
		chk(asp_pkg::A_BAUD, 16'hffff, 16'h0001);
		chk(asp_pkg::A_CTRL, 16'hffff, 16'h0c00);
		chk(asp_pkg::A_STAT, 16'h00c0, 16'h00c0);
		cmp({15'h0, irq_abd}, 16'h0001);
		conclude();
	end
endmodule : asp_serial_port_tb
